//--- verilog/pmc_power_ctrl.sv
/*
 * Power mode and clock control: normal, sleep, standby and per-module
 * standby, plus clock ratio and divider control of the clock generator.
 * Assumes the CPU pulses a sleep request, interrupt, non-maskable interrupt
 * and wake events arrive on pins, and the registers are reached over a
 * simple strobe port with read data one cycle after the read strobe.
 */
// Local design decisions: strobed register access and the register addresses.
// Contract
// - Sleep halts CPU execution while the clock generator and peripherals run.
// - Sleep request with standby select clear enters sleep; interrupt or reset leaves.
// - During sleep memories and registers hold and external refresh continues.
// - Standby stops CPU, clock generator and peripherals, holding all contents.
// - Sleep request with standby select set enters standby; only NMI or reset leaves.
// - Leaving standby waits for the clock generator to settle before resuming.
// - External dynamic memory is put into self-refresh during standby.
// - Module standby withholds the clock from each selected peripheral only.
// - A module in standby keeps its state or is held in its initial state.
// - Module standby applies together with normal and sleep operation.
// - The PLL ratio is one, two or four, selectable by software at any time.
// - A basic external bus cycle lasts two processor clocks at every ratio; the bus enable here pulses every one, two or four clocks by ratio.
// - CPU clock runs at one, two or four times the bus clock.
// - Peripheral clock is the CPU clock divided by two or four.
// - The watchdog counter may time the settling interval after an NMI wake.
`timescale 1ns/100ps
`default_nettype none
module pmc_power_ctrl #(
    parameter int NUM_MODULES = 8,
    parameter int SETTLE_COUNT = pmc_pkg::SETTLE_CYCLES
) (
    input wire logic CORE_CLK_IN,            // Core clock, 200 MHz.
    input wire logic RST_B_IN,               // Synchronous reset, active low.
    input wire logic CLK_EN_IN,              // Freezes all state while low.
    input wire logic [3:0] ADDR_IN,          // Register byte address.
    input wire logic [7:0] WDATA_IN,         // Register write data.
    input wire logic WR_IN,                  // Write strobe.
    input wire logic RD_IN,                  // Read strobe.
    output logic [7:0] RDATA_OUT,            // Read data, cycle after strobe.
    input wire logic SLEEP_REQ_IN,           // CPU executed sleep instruction.
    input wire logic IRQ_IN,                 // Any interrupt request, pin.
    input wire logic NMI_IN,                 // Non-maskable interrupt, pin.
    input wire logic WDT_SETTLED_IN,         // Watchdog settle done pulse.
    input wire logic USE_WDT_IN,             // Use watchdog for settling.
    output logic CPU_RUN_OUT,                // CPU may execute.
    output logic PER_RUN_OUT,                // Peripherals clocked.
    output logic OSC_RUN_OUT,                // Clock generator running.
    output logic REFRESH_EN_OUT,             // Auto refresh of external DRAM.
    output logic SELF_REFRESH_OUT,           // DRAM self-refresh request.
    output logic [NUM_MODULES-1:0] MOD_CLK_EN_OUT, // Per-module clock enable.
    output logic [NUM_MODULES-1:0] MOD_INIT_OUT,   // Per-module hold in reset.
    output logic [1:0] PLL_RATIO_OUT,        // PLL multiply select.
    output logic CPU_CE_OUT,                 // CPU clock enable.
    output logic PER_CE_OUT,                 // Peripheral clock enable.
    output logic BUS_CE_OUT                  // External bus clock enable.
);
    // Parameter values the logic cannot serve stop elaboration.
    // The module standby register is one byte wide, hence one to eight modules.
    generate
        if (NUM_MODULES < 1 || NUM_MODULES > 8) begin : g_bad_modules
            $error("NUM_MODULES must be 1 to 8");
        end
        // The settling counter must reach its end value at least once.
        if (SETTLE_COUNT < 1) begin : g_bad_settle
            $error("SETTLE_COUNT must be at least 1");
        end
    endgenerate

    logic [2:0] irq_sync_reg;
    logic [2:0] nmi_sync_reg;
    logic irq_lvl_reg;
    logic nmi_lvl_reg;
    logic nmi_prev_reg;
    logic nmi_rise;
    logic [7:0] pwr_ctrl_reg;
    logic [7:0] mod_standby_select_bit_alt_reg;
    logic [7:0] clk_ctrl_reg;
    pmc_pkg::pmc_state_t state_reg;
    pmc_pkg::pmc_state_t state_next;
    logic [31:0] settle_cnt_reg;
    logic [2:0] div_cnt_reg;
    logic [2:0] bus_mask;
    logic [2:0] per_mask;
    logic [7:0] rdata_next;

    // Three-stage synchronisers; a level changes once stages two and three agree.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            irq_sync_reg <= 3'h0;
            nmi_sync_reg <= 3'h0;
        end else if (CLK_EN_IN) begin
            irq_sync_reg <= {irq_sync_reg[1:0], IRQ_IN};
            nmi_sync_reg <= {nmi_sync_reg[1:0], NMI_IN};
        end
    end

    // Interrupt level, filtered so a single-cycle glitch never wakes sleep.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            irq_lvl_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (irq_sync_reg[2] == irq_sync_reg[1]) begin
                irq_lvl_reg <= irq_sync_reg[2];
            end
        end
    end

    // The previous level is kept so standby sees only a fresh NMI edge.
    // A level held high from before standby therefore cannot wake the part.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            nmi_lvl_reg <= 1'b0;
            nmi_prev_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (nmi_sync_reg[2] == nmi_sync_reg[1]) begin
                nmi_lvl_reg <= nmi_sync_reg[2];
            end
            nmi_prev_reg <= nmi_lvl_reg;
        end
    end

    assign nmi_rise = nmi_lvl_reg & ~nmi_prev_reg;

    // Register writes; clock ratio may change at any time.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            pwr_ctrl_reg <= pmc_pkg::RST_PWR_CTRL;
            mod_standby_select_bit_alt_reg <= 8'h00;
            clk_ctrl_reg <= pmc_pkg::RST_CLK_CTRL;
        end else if (CLK_EN_IN && WR_IN) begin
            if (ADDR_IN == pmc_pkg::OFF_PWR_CTRL) begin
                pwr_ctrl_reg <= WDATA_IN & 8'h81;
            end else if (ADDR_IN == pmc_pkg::OFF_MOD_STANDBY_SELECT_BIT_ALT) begin
                mod_standby_select_bit_alt_reg <= WDATA_IN;
            end else if (ADDR_IN == pmc_pkg::OFF_CLK_CTRL) begin
                if (WDATA_IN[1:0] != 2'h3) begin
                    clk_ctrl_reg[1:0] <= WDATA_IN[1:0];
                end
                if (WDATA_IN[3:2] == pmc_pkg::PER_DIV2 ||
                    WDATA_IN[3:2] == pmc_pkg::PER_DIV4) begin
                    clk_ctrl_reg[3:2] <= WDATA_IN[3:2];
                end
                if (WDATA_IN[5:4] != 2'h3) begin
                    clk_ctrl_reg[5:4] <= WDATA_IN[5:4];
                end
            end
        end
    end

    // Power state machine.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pmc_pkg::ST_NORMAL: begin
                if (SLEEP_REQ_IN) begin
                    if (pwr_ctrl_reg[pmc_pkg::BIT_STANDBY_SELECT_BIT_ALT_SEL]) begin
                        state_next = pmc_pkg::ST_STANDBY;
                    end else begin
                        state_next = pmc_pkg::ST_SLEEP;
                    end
                end
            end
            pmc_pkg::ST_SLEEP: begin
                if (irq_lvl_reg || nmi_lvl_reg) begin
                    state_next = pmc_pkg::ST_NORMAL;
                end
            end
            pmc_pkg::ST_STANDBY: begin
                if (nmi_rise) begin
                    state_next = pmc_pkg::ST_SETTLE;
                end
            end
            pmc_pkg::ST_SETTLE: begin
                if (USE_WDT_IN ? WDT_SETTLED_IN :
                    settle_cnt_reg == 32'(SETTLE_COUNT - 1)) begin
                    state_next = pmc_pkg::ST_NORMAL;
                end
            end
            default: begin
                state_next = pmc_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            state_reg <= pmc_pkg::ST_NORMAL;
        end else if (CLK_EN_IN) begin
            state_reg <= state_next;
        end
    end

    // Settling counter runs only while the oscillator restarts.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            settle_cnt_reg <= 32'h0;
        end else if (CLK_EN_IN) begin
            if (state_reg == pmc_pkg::ST_SETTLE) begin
                settle_cnt_reg <= settle_cnt_reg + 32'h1;
            end else begin
                settle_cnt_reg <= 32'h0;
            end
        end
    end

    // Clock-enable divider; the bus enable pulses at a ratio-derived rate.
    always_comb begin
        case (clk_ctrl_reg[1:0])
            pmc_pkg::RATIO_X2: bus_mask = 3'h1;
            pmc_pkg::RATIO_X4: bus_mask = 3'h3;
            default: bus_mask = 3'h0;
        endcase
        if (clk_ctrl_reg[3:2] == pmc_pkg::PER_DIV4) begin
            per_mask = 3'h3;
        end else begin
            per_mask = 3'h1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            div_cnt_reg <= 3'h0;
        end else if (CLK_EN_IN) begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
    end

    // Run levels follow the next state so they change with the state.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            CPU_RUN_OUT <= 1'b1;
            PER_RUN_OUT <= 1'b1;
            OSC_RUN_OUT <= 1'b1;
        end else if (CLK_EN_IN) begin
            CPU_RUN_OUT <= state_next == pmc_pkg::ST_NORMAL;
            PER_RUN_OUT <= state_next == pmc_pkg::ST_NORMAL ||
                           state_next == pmc_pkg::ST_SLEEP;
            OSC_RUN_OUT <= state_next != pmc_pkg::ST_STANDBY;
        end
    end

    // External memory refresh; self-refresh covers the settling time too.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            REFRESH_EN_OUT <= 1'b1;
            SELF_REFRESH_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            REFRESH_EN_OUT <= state_next == pmc_pkg::ST_NORMAL ||
                              state_next == pmc_pkg::ST_SLEEP;
            SELF_REFRESH_OUT <= state_next == pmc_pkg::ST_STANDBY ||
                                state_next == pmc_pkg::ST_SETTLE;
        end
    end

    // Clock enables for the CPU, peripheral and bus domains.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            CPU_CE_OUT <= 1'b0;
            PER_CE_OUT <= 1'b0;
            BUS_CE_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            CPU_CE_OUT <= state_next == pmc_pkg::ST_NORMAL;
            PER_CE_OUT <= (state_next == pmc_pkg::ST_NORMAL ||
                           state_next == pmc_pkg::ST_SLEEP) &&
                          ((div_cnt_reg & per_mask) == per_mask);
            // Two processor clocks per basic bus cycle at the x1 ratio.
            BUS_CE_OUT <= (state_next == pmc_pkg::ST_NORMAL ||
                           state_next == pmc_pkg::ST_SLEEP) &&
                          ((div_cnt_reg & bus_mask) == bus_mask);
        end
    end

    // Multiply select follows the stored ratio at any time.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            PLL_RATIO_OUT <= pmc_pkg::RATIO_X1;
        end else if (CLK_EN_IN) begin
            PLL_RATIO_OUT <= clk_ctrl_reg[1:0];
        end
    end

    // Per-module gating; every module clock also stops in standby and settling.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi++) begin : g_mod
            always_ff @(posedge CORE_CLK_IN) begin
                if (!RST_B_IN) begin
                    MOD_CLK_EN_OUT[gi] <= 1'b1;
                    MOD_INIT_OUT[gi] <= 1'b0;
                end else if (CLK_EN_IN) begin
                    MOD_CLK_EN_OUT[gi] <= ~mod_standby_select_bit_alt_reg[gi] &&
                        state_next != pmc_pkg::ST_STANDBY &&
                        state_next != pmc_pkg::ST_SETTLE;
                    MOD_INIT_OUT[gi] <= mod_standby_select_bit_alt_reg[gi] &
                        pwr_ctrl_reg[pmc_pkg::BIT_MOD_INIT];
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses return zero.
    always_comb begin
        rdata_next = 8'h00;
        if (ADDR_IN == pmc_pkg::OFF_PWR_CTRL) begin
            rdata_next = pwr_ctrl_reg;
        end else if (ADDR_IN == pmc_pkg::OFF_MOD_STANDBY_SELECT_BIT_ALT) begin
            rdata_next = mod_standby_select_bit_alt_reg;
        end else if (ADDR_IN == pmc_pkg::OFF_CLK_CTRL) begin
            rdata_next = clk_ctrl_reg & 8'h3F;
        end else if (ADDR_IN == pmc_pkg::OFF_STATUS) begin
            rdata_next = {4'h0, state_reg};
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (CLK_EN_IN) begin
            if (RD_IN) begin
                RDATA_OUT <= rdata_next;
            end else begin
                RDATA_OUT <= 8'h00;
            end
        end
    end
endmodule : pmc_power_ctrl
`default_nettype wire

//--- verilog/pmc_pkg.sv
/*
 * Constants for the power mode and clock control block: register offsets,
 * field positions, reset values, mode encodings and settling counts.
 * Assumes a single 200 MHz core clock.
 */
package pmc_pkg;
    localparam logic [3:0] OFF_PWR_CTRL = 4'h0;
    localparam logic [3:0] OFF_MOD_STANDBY_SELECT_BIT_ALT = 4'h4;
    localparam logic [3:0] OFF_CLK_CTRL = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;

    localparam int BIT_STANDBY_SELECT_BIT_ALT_SEL = 7;
    localparam int BIT_MOD_INIT = 0;
    localparam int POS_PLL_RATIO = 0;
    localparam int POS_PER_DIV = 2;
    localparam int POS_BUS_DIV = 4;

    localparam logic [1:0] RATIO_X1 = 2'h0;
    localparam logic [1:0] RATIO_X2 = 2'h1;
    localparam logic [1:0] RATIO_X4 = 2'h2;
    localparam logic [1:0] PER_DIV2 = 2'h1;
    localparam logic [1:0] PER_DIV4 = 2'h2;

    localparam logic [7:0] RST_PWR_CTRL = 8'h00;
    localparam logic [7:0] RST_CLK_CTRL = 8'h00;

    localparam int CLK_MHZ = 200;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    localparam int BUS_CYCLE_CLKS = 2;

    typedef enum logic [3:0] {
        ST_NORMAL = 4'h1,
        ST_SLEEP = 4'h2,
        ST_STANDBY = 4'h4,
        ST_SETTLE = 4'h8
    } pmc_state_t;
endpackage : pmc_pkg

//--- test/pmc_power_ctrl_monitor.sv
/* Checker for the power mode and clock control block ports.
   Assumes a bind to the top module and one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module pmc_power_ctrl_monitor #(
    parameter int NUM_MODULES = 8
) (
    input wire logic CORE_CLK_IN, // Core clock.
    input wire logic RST_B_IN, // Reset, active low.
    input wire logic CLK_EN_IN, // Run enable.
    input wire logic [3:0] ADDR_IN, // Register address.
    input wire logic RD_IN, // Read strobe.
    input wire logic SLEEP_REQ_IN, // Sleep request.
    input wire logic NMI_IN, // Non-maskable interrupt.
    input wire logic [7:0] RDATA_OUT, // Read data.
    input wire logic CPU_RUN_OUT, // CPU may execute.
    input wire logic PER_RUN_OUT, // Peripherals run.
    input wire logic OSC_RUN_OUT, // Clock generator runs.
    input wire logic SELF_REFRESH_OUT, // Self-refresh request.
    input wire logic [NUM_MODULES-1:0] MOD_CLK_EN_OUT, // Module clocks.
    input wire logic [NUM_MODULES-1:0] MOD_INIT_OUT, // Module init.
    input wire logic [1:0] PLL_RATIO_OUT, // Multiply select.
    input wire logic PER_CE_OUT, // Peripheral enable.
    input wire logic BUS_CE_OUT // Bus enable.
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    property p_sleep_entry;
        SLEEP_REQ_IN && CPU_RUN_OUT && CLK_EN_IN |=> !CPU_RUN_OUT;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("CPU kept running after sleep request");
    property p_standby_halt;
        !OSC_RUN_OUT |-> !CPU_RUN_OUT && !PER_RUN_OUT && SELF_REFRESH_OUT
            && MOD_CLK_EN_OUT == '0;
    endproperty
    a_standby_halt: assert property (p_standby_halt)
        else $error("Something runs while oscillator is stopped");
    property p_standby_irq;
        !OSC_RUN_OUT && !NMI_IN |=> !CPU_RUN_OUT;
    endproperty
    a_standby_irq: assert property (p_standby_irq)
        else $error("Standby left without NMI");
    property p_settle;
        $rose(OSC_RUN_OUT) |-> !CPU_RUN_OUT [*3];
    endproperty
    a_settle: assert property (p_settle)
        else $error("CPU resumed before oscillator settled");
    property p_init_stop;
        (MOD_INIT_OUT & MOD_CLK_EN_OUT) == '0;
    endproperty
    a_init_stop: assert property (p_init_stop)
        else $error("Module clocked while held in init");
    property p_status;
        RD_IN && CLK_EN_IN && ADDR_IN == pmc_pkg::OFF_STATUS |=>
            $onehot(RDATA_OUT[3:0]) && RDATA_OUT[7:4] == 4'h0;
    endproperty
    a_status: assert property (p_status)
        else $error("Status read is not one state");
    property p_bus_x2;
        BUS_CE_OUT && PLL_RATIO_OUT == pmc_pkg::RATIO_X2 ##1
            PLL_RATIO_OUT == pmc_pkg::RATIO_X2 |-> !BUS_CE_OUT;
    endproperty
    a_bus_x2: assert property (p_bus_x2)
        else $error("Bus enable too frequent at ratio two");
    property p_per_ce;
        PER_CE_OUT && CLK_EN_IN |=> !PER_CE_OUT;
    endproperty
    a_per_ce: assert property (p_per_ce)
        else $error("Peripheral enable on two cycles running");
    property p_ratio;
        PLL_RATIO_OUT != 2'h3;
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("Illegal multiply ratio");
    property p_reset;
        $rose(RST_B_IN) |-> CPU_RUN_OUT && MOD_CLK_EN_OUT == '1
            && MOD_INIT_OUT == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Wrong state after reset");
    c_sleep: cover property (SLEEP_REQ_IN && CPU_RUN_OUT);
    c_standby: cover property (!OSC_RUN_OUT);
    c_settle: cover property ($rose(OSC_RUN_OUT));
endmodule : pmc_power_ctrl_monitor
`default_nettype wire

//--- test/pmc_power_ctrl_test.sv
/* Self-checking bench for the power mode and clock control block.
   Assumes the package and design are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module pmc_power_ctrl_test;
    localparam int SETTLE = 4;
    logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
    logic sleep_req = 1'b0, irq = 1'b0, nmi = 1'b0, wdt = 1'b0, use_wdt = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, mod_clk, mod_init;
    logic cpu_run, per_run, osc_run, refresh, self_ref, cpu_ce, per_ce, bus_ce;
    logic [1:0] ratio;
    int err_count = 0, checks = 0, cyc = 0, n, g;
    pmc_power_ctrl #(.NUM_MODULES(8), .SETTLE_COUNT(SETTLE)) pmc_power_ctrl_inst (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(clk_en),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .SLEEP_REQ_IN(sleep_req), .IRQ_IN(irq),
        .NMI_IN(nmi), .WDT_SETTLED_IN(wdt), .USE_WDT_IN(use_wdt),
        .CPU_RUN_OUT(cpu_run), .PER_RUN_OUT(per_run), .OSC_RUN_OUT(osc_run),
        .REFRESH_EN_OUT(refresh), .SELF_REFRESH_OUT(self_ref),
        .MOD_CLK_EN_OUT(mod_clk), .MOD_INIT_OUT(mod_init),
        .PLL_RATIO_OUT(ratio), .CPU_CE_OUT(cpu_ce), .PER_CE_OUT(per_ce),
        .BUS_CE_OUT(bus_ce));
    initial forever #2.5 clk = ~clk;
    task automatic results;
        $display("err_count %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // A hang is cut short here and counted as a mismatch.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic s);
        chk8(nm, {7'h00, e}, {7'h00, s});
    endtask : chk1
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(nm, e, rdata);
    endtask : rd_chk
    task automatic sleep_cmd;
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        #1;
    endtask : sleep_cmd
    task automatic wake_wait(input int lim);
        n = 0;
        while (cpu_run !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask : wake_wait
    // Cycles between two enable pulses, skipping the first after a change.
    task automatic spacing(input bit per);
        repeat (2) begin
            do @(negedge clk); while ((per ? per_ce : bus_ce) !== 1'b1);
            g = 0;
            do begin @(negedge clk); g++; end while ((per ? per_ce : bus_ce) !== 1'b1);
        end
    endtask : spacing
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk1("cpu_run", 1'b1, cpu_run);
        chk8("mod_clk", 8'hFF, mod_clk);
        rd_chk("pwr", pmc_pkg::OFF_PWR_CTRL, pmc_pkg::RST_PWR_CTRL);
        rd_chk("mod", pmc_pkg::OFF_MOD_STANDBY_SELECT_BIT_ALT, 8'h00);
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h01);
        wr_reg(pmc_pkg::OFF_PWR_CTRL, 8'hFF);
        rd_chk("pwr", pmc_pkg::OFF_PWR_CTRL, 8'h81);
        rd_chk("unmapped", 4'h2, 8'h00);
        wr_reg(pmc_pkg::OFF_MOD_STANDBY_SELECT_BIT_ALT, 8'h05);
        repeat (2) @(posedge clk);
        #1 chk8("mod_clk", 8'hFA, mod_clk);
        chk8("mod_init", 8'h05, mod_init);
        chk1("cpu_run", 1'b1, cpu_run);
        wr_reg(pmc_pkg::OFF_PWR_CTRL, 8'h01);
        sleep_cmd();
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h02);
        chk1("cpu_run", 1'b0, cpu_run);
        chk1("cpu_ce", 1'b0, cpu_ce);
        chk1("osc_run", 1'b1, osc_run);
        chk1("per_run", 1'b1, per_run);
        chk1("refresh", 1'b1, refresh);
        chk8("mod_clk", 8'hFA, mod_clk);
        rd_chk("mod", pmc_pkg::OFF_MOD_STANDBY_SELECT_BIT_ALT, 8'h05);
        irq <= 1'b1;
        wake_wait(20);
        irq <= 1'b0;
        chk1("sleep wake", 1'b1, cpu_run);
        chk1("cpu_ce", 1'b1, cpu_ce);
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h01);
        wr_reg(pmc_pkg::OFF_PWR_CTRL, 8'h80);
        sleep_cmd();
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h04);
        chk1("osc_run", 1'b0, osc_run);
        chk1("per_run", 1'b0, per_run);
        chk1("self_ref", 1'b1, self_ref);
        irq <= 1'b1;
        repeat (10) @(posedge clk);
        irq <= 1'b0;
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h04);
        nmi <= 1'b1;
        wake_wait(100);
        nmi <= 1'b0;
        chk1("settle wait", 1'b1, n >= SETTLE);
        chk1("osc_run", 1'b1, osc_run);
        use_wdt <= 1'b1;
        sleep_cmd();
        nmi <= 1'b1;
        repeat (30) @(posedge clk);
        nmi <= 1'b0;
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h08);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        wake_wait(5);
        chk1("wdt wake", 1'b1, cpu_run);
        use_wdt <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            wr_reg(pmc_pkg::OFF_CLK_CTRL, {4'h0, pmc_pkg::PER_DIV2, 2'(r)});
            spacing(1'b0);
            chk8("ratio", 8'(r), {6'h00, ratio});
            chk8("bus gap", 8'(1 << r), 8'(g));
        end
        wr_reg(pmc_pkg::OFF_CLK_CTRL, 8'h07);
        repeat (2) @(posedge clk);
        #1 chk8("ratio kept", {6'h00, pmc_pkg::RATIO_X4}, {6'h00, ratio});
        for (int d = 1; d < 3; d++) begin
            wr_reg(pmc_pkg::OFF_CLK_CTRL, {4'h0, 2'(d), 2'h0});
            spacing(1'b1);
            chk8("per gap", 8'(2 * d), 8'(g));
        end
        wr_reg(pmc_pkg::OFF_MOD_STANDBY_SELECT_BIT_ALT, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk8("mod_clk", 8'hFF, mod_clk);
        @(posedge clk);
        clk_en <= 1'b0;
        sleep_cmd();
        repeat (3) @(posedge clk);
        #1 chk1("frozen cpu_run", 1'b1, cpu_run);
        @(posedge clk);
        clk_en <= 1'b1;
        rd_chk("status", pmc_pkg::OFF_STATUS, 8'h01);
        results();
    end
endmodule : pmc_power_ctrl_test
bind pmc_power_ctrl pmc_power_ctrl_monitor #(.NUM_MODULES(NUM_MODULES))
    pmc_power_ctrl_monitor_inst (.CORE_CLK_IN(CORE_CLK_IN),
    .RST_B_IN(RST_B_IN), .CLK_EN_IN(CLK_EN_IN), .ADDR_IN(ADDR_IN),
    .RD_IN(RD_IN), .SLEEP_REQ_IN(SLEEP_REQ_IN), .NMI_IN(NMI_IN),
    .RDATA_OUT(RDATA_OUT), .CPU_RUN_OUT(CPU_RUN_OUT),
    .PER_RUN_OUT(PER_RUN_OUT), .OSC_RUN_OUT(OSC_RUN_OUT),
    .SELF_REFRESH_OUT(SELF_REFRESH_OUT), .MOD_CLK_EN_OUT(MOD_CLK_EN_OUT),
    .MOD_INIT_OUT(MOD_INIT_OUT), .PLL_RATIO_OUT(PLL_RATIO_OUT),
    .PER_CE_OUT(PER_CE_OUT), .BUS_CE_OUT(BUS_CE_OUT));
`default_nettype wire
